// ===== sshcu_consts.vh
// constants of the sensor head serial command unit
`ifndef SSHCU_CONSTS_VH
`define SSHCU_CONSTS_VH
`define SSHCU_ADR_CTRL 4'h0
`define SSHCU_ADR_STAT 4'h4
`define SSHCU_ADR_IRQS 4'h8
`define SSHCU_ADR_IRQM 4'hC
`define SSHCU_BAUD_115200 115200
`define SSHCU_BAUD_57600 57600
`define SSHCU_BAUD_38400 38400
`define SSHCU_BAUD_19200 19200
`define SSHCU_BAUD_9600 9600
`define SSHCU_BAUD_4800 4800
`define SSHCU_SEL_115200 3'h0
`define SSHCU_SEL_57600 3'h1
`define SSHCU_SEL_38400 3'h2
`define SSHCU_SEL_19200 3'h3
`define SSHCU_SEL_9600 3'h4
`define SSHCU_SEL_4800 3'h5
`define SSHCU_PAR_NONE 2'h0
`define SSHCU_PAR_EVEN 2'h1
`define SSHCU_PAR_ODD 2'h2
`define SSHCU_FRAME_BASE 4'hA
`define SSHCU_MSG_DEPTH 6
`define SSHCU_ASC_ACK 8'h06
`define SSHCU_ASC_NAK 8'h15
`define SSHCU_ASC_CR 8'h0D
`define SSHCU_ASC_D 8'h44
`define SSHCU_ASC_A 8'h41
`define SSHCU_ASC_E 8'h45
`define SSHCU_ASC_S 8'h53
`define SSHCU_ASC_ONE 8'h31
`define SSHCU_ERR_NOHEAD 8'h31
`define SSHCU_ERR_DISC 8'h32
`define SSHCU_ERR_IFACE 8'h36
`define SSHCU_ERR_FORMAT 8'h37
`define SSHCU_ERR_PARAM 8'h38
`define SSHCU_IRQ_CMD 0
`define SSHCU_IRQ_NAK 1
`define SSHCU_IRQ_RXERR 2
`endif

// ===== sshcu_top.v
// serial command unit of a remote temperature output head
// How it works
// - link runs at 115200 to 4800 baud; reset selects 115200.
// - one or two stop bits, even, odd or no parity, set by software.
// - in command mode data goes out only in answer to a data command.
// - in auto mode with head present, data goes out on each change.
// - auto stop command enters command mode and answers ACK, else NAK code.
// - auto start command enters auto mode and answers ACK, else NAK code.
// - commands and codes are ASCII; control bytes are hex values.
// - code 1 when the transmission head gives no reply.
// - code 2 when the asked sensor input is not connected.
// - code 6 when a received character breaks the frame settings.
// - code 7 for a malformed command, code 8 for a bad parameter.
// - rts output high while a transmission head is in zone, else low.
`include "sshcu_consts.vh"
`default_nettype none
module sshcu_top #(
   parameter CH = 8,
   parameter CLK_HZ = 25000000,
   parameter DIV_4800 = CLK_HZ / `SSHCU_BAUD_4800
) (
   input wire clk_i,
   input wire rst_i,
   input wire [3:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg wb_ack_o,
   input wire rxd_i,
   output reg txd_o,
   input wire head_in_zone_i,
   output reg rts_o,
   input wire [CH*16-1:0] temp_i,
   input wire [CH-1:0] sensor_conn_i,
   output wire irq_o
);
   localparam DIV_115200 = CLK_HZ / `SSHCU_BAUD_115200;
   localparam DIV_57600 = CLK_HZ / `SSHCU_BAUD_57600;
   localparam DIV_38400 = CLK_HZ / `SSHCU_BAUD_38400;
   localparam DIV_19200 = CLK_HZ / `SSHCU_BAUD_19200;
   localparam DIV_9600 = CLK_HZ / `SSHCU_BAUD_9600;
   localparam [1:0] P_IDLE = 2'h0;
   localparam [1:0] P_A = 2'h1;
   localparam [1:0] P_D = 2'h2;

   reg [2:0] baud_sel_r;
   reg stop2_r;
   reg [1:0] par_r;
   reg [2:0] auto_ch_r;
   reg auto_r;
   reg [2:0] irq_stat_r;
   reg [2:0] irq_mask_r;
   reg [12:0] bit_div;
   wire par_en = (par_r == `SSHCU_PAR_EVEN) | (par_r == `SSHCU_PAR_ODD);
   wire par_odd = (par_r == `SSHCU_PAR_ODD);
   wire wb_req = wb_cyc_i & wb_stb_i;
   wire wb_wr = wb_req & wb_ack_o & wb_we_i;

   // bit period per baud select
   always @* begin
      case (baud_sel_r)
         `SSHCU_SEL_57600: bit_div = DIV_57600[12:0];
         `SSHCU_SEL_38400: bit_div = DIV_38400[12:0];
         `SSHCU_SEL_19200: bit_div = DIV_19200[12:0];
         `SSHCU_SEL_9600: bit_div = DIV_9600[12:0];
         `SSHCU_SEL_4800: bit_div = DIV_4800[12:0];
         default: bit_div = DIV_115200[12:0];
      endcase
   end

   // pin synchronisers: change taken once stages two and three agree
   reg rx_s1, rx_s2, rx_s3, rx_lvl;
   reg hd_s1, hd_s2, hd_s3, head_lvl;
   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_s3 <= 1'b1;
         rx_lvl <= 1'b1;
         hd_s1 <= 1'b0;
         hd_s2 <= 1'b0;
         hd_s3 <= 1'b0;
         head_lvl <= 1'b0;
         rts_o <= 1'b0;
      end else begin
         rx_s1 <= rxd_i;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         if (rx_s2 == rx_s3)
            rx_lvl <= rx_s3;
         hd_s1 <= head_in_zone_i;
         hd_s2 <= hd_s1;
         hd_s3 <= hd_s2;
         if (hd_s2 == hd_s3)
            head_lvl <= hd_s3;
         rts_o <= head_lvl;
      end
   end

   // receiver
   reg rx_busy;
   reg [12:0] rx_cnt;
   reg [3:0] rx_bit;
   reg [7:0] rx_dat;
   reg rx_par;
   reg rx_done;
   reg rx_err;
   wire [3:0] rx_last = `SSHCU_FRAME_BASE - 4'h1 + {3'h0, par_en};
   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_busy <= 1'b0;
         rx_cnt <= 13'h0000;
         rx_bit <= 4'h0;
         rx_dat <= 8'h00;
         rx_par <= 1'b0;
         rx_done <= 1'b0;
         rx_err <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (!rx_busy) begin
            if (!rx_lvl) begin
               rx_busy <= 1'b1;
               rx_cnt <= bit_div >> 1;
               rx_bit <= 4'h0;
            end
         end else if (rx_cnt != 13'h0000) begin
            rx_cnt <= rx_cnt - 13'h0001;
         end else begin
            rx_cnt <= bit_div - 13'h0001;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rx_lvl) begin
               rx_busy <= 1'b0;
            end else if (rx_bit != 4'h0 && rx_bit <= 4'h8) begin
               rx_dat <= {rx_lvl, rx_dat[7:1]};
            end else if (rx_bit != rx_last) begin
               rx_par <= rx_lvl;
            end else begin
               rx_busy <= 1'b0;
               rx_done <= 1'b1;
               rx_err <= ~rx_lvl | (par_en & (rx_par != (^rx_dat ^ par_odd)));
            end
         end
      end
   end

   // transmitter; stop bits and parity follow the frame settings
   reg [10:0] tx_sh;
   reg [3:0] tx_left;
   reg [12:0] tx_cnt;
   wire tx_busy = (tx_left != 4'h0);
   reg [7:0] msg_r [0:`SSHCU_MSG_DEPTH-1];
   reg [2:0] msg_len_r;
   reg [2:0] msg_idx_r;
   wire msg_pend = (msg_idx_r != msg_len_r);
   wire sending = msg_pend | tx_busy;
   wire [7:0] tx_byte = msg_r[msg_idx_r];
   wire tx_pbit = ^tx_byte ^ par_odd;
   always @(posedge clk_i) begin
      if (rst_i) begin
         tx_sh <= 11'h7FF;
         tx_left <= 4'h0;
         tx_cnt <= 13'h0000;
         txd_o <= 1'b1;
      end else if (!tx_busy) begin
         if (msg_pend) begin
            txd_o <= 1'b0;
            tx_sh <= {2'b11, par_en ? tx_pbit : 1'b1, tx_byte};
            tx_left <= `SSHCU_FRAME_BASE + {3'h0, par_en} + {3'h0, stop2_r};
            tx_cnt <= bit_div - 13'h0001;
         end
      end else if (tx_cnt != 13'h0000) begin
         tx_cnt <= tx_cnt - 13'h0001;
      end else begin
         tx_cnt <= bit_div - 13'h0001;
         tx_left <= tx_left - 4'h1;
         txd_o <= tx_sh[0];
         tx_sh <= {1'b1, tx_sh[10:1]};
      end
   end

   function [7:0] hex_asc;
      input [3:0] n;
      begin
         hex_asc = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
      end
   endfunction

   // command parser and answer builder
   reg [1:0] p_st;
   reg [15:0] last_r;
   reg ev_cmd, ev_nak;
   wire [7:0] ch_off = rx_dat - `SSHCU_ASC_ONE;
   wire ch_ok = (rx_dat >= `SSHCU_ASC_ONE) && (ch_off < CH);
   wire [2:0] rx_ch = ch_off[2:0];
   wire [15:0] rx_temp = temp_i[rx_ch*16 +: 16];
   wire [15:0] auto_temp = temp_i[auto_ch_r*16 +: 16];
   wire auto_go = auto_r & head_lvl & (auto_temp != last_r) & (p_st == P_IDLE);
   integer i;

   task put_ack;
      begin
         msg_r[0] <= `SSHCU_ASC_ACK;
         msg_len_r <= 3'h1;
         ev_cmd <= 1'b1;
      end
   endtask

   task put_nak;
      input [7:0] code;
      begin
         msg_r[0] <= `SSHCU_ASC_NAK;
         msg_r[1] <= code;
         msg_len_r <= 3'h2;
         ev_nak <= 1'b1;
      end
   endtask

   task put_data;
      input [2:0] ch;
      input [15:0] t;
      begin
         msg_r[0] <= `SSHCU_ASC_ONE + {5'h00, ch};
         msg_r[1] <= hex_asc(t[15:12]);
         msg_r[2] <= hex_asc(t[11:8]);
         msg_r[3] <= hex_asc(t[7:4]);
         msg_r[4] <= hex_asc(t[3:0]);
         msg_r[5] <= `SSHCU_ASC_CR;
         msg_len_r <= 3'h6;
      end
   endtask

   always @(posedge clk_i) begin
      if (rst_i) begin
         p_st <= P_IDLE;
         auto_r <= 1'b0;
         last_r <= 16'h0000;
         msg_len_r <= 3'h0;
         msg_idx_r <= 3'h0;
         ev_cmd <= 1'b0;
         ev_nak <= 1'b0;
         for (i = 0; i < `SSHCU_MSG_DEPTH; i = i + 1)
            msg_r[i] <= 8'h00;
      end else begin
         ev_cmd <= 1'b0;
         ev_nak <= 1'b0;
         if (!tx_busy && msg_pend)
            msg_idx_r <= msg_idx_r + 3'h1;
         if (!sending && rx_done) begin
            msg_idx_r <= 3'h0;
            msg_len_r <= 3'h0;
            p_st <= P_IDLE;
            if (rx_err) begin
               put_nak(`SSHCU_ERR_IFACE);
            end else begin
               case (p_st)
                  P_IDLE: begin
                     if (rx_dat == `SSHCU_ASC_D)
                        p_st <= P_D;
                     else if (rx_dat == `SSHCU_ASC_A)
                        p_st <= P_A;
                     else
                        put_nak(`SSHCU_ERR_FORMAT);
                  end
                  P_A: begin
                     if (rx_dat == `SSHCU_ASC_E) begin
                        auto_r <= 1'b0;
                        put_ack;
                     end else if (rx_dat == `SSHCU_ASC_S) begin
                        auto_r <= 1'b1;
                        last_r <= auto_temp;
                        put_ack;
                     end else begin
                        put_nak(`SSHCU_ERR_FORMAT);
                     end
                  end
                  P_D: begin
                     if (!ch_ok)
                        put_nak(`SSHCU_ERR_PARAM);
                     else if (!head_lvl)
                        put_nak(`SSHCU_ERR_NOHEAD);
                     else if (!sensor_conn_i[rx_ch])
                        put_nak(`SSHCU_ERR_DISC);
                     else begin
                        put_data(rx_ch, rx_temp);
                        ev_cmd <= 1'b1;
                     end
                  end
                  default: p_st <= P_IDLE;
               endcase
            end
         end else if (!sending && !rx_done && auto_go) begin
            msg_idx_r <= 3'h0;
            last_r <= auto_temp;
            put_data(auto_ch_r, auto_temp);
         end
      end
   end

   // register slave, one wait state, unmapped reads zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         baud_sel_r <= `SSHCU_SEL_115200;
         stop2_r <= 1'b0;
         par_r <= `SSHCU_PAR_NONE;
         auto_ch_r <= 3'h0;
         irq_mask_r <= 3'h0;
         irq_stat_r <= 3'h0;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         wb_dat_o <= 32'h00000000;
         case (wb_adr_i)
            `SSHCU_ADR_CTRL:
               wb_dat_o <= {21'h000000, auto_ch_r, 2'h0, par_r, stop2_r, baud_sel_r};
            `SSHCU_ADR_STAT: wb_dat_o <= {29'h00000000, sending, head_lvl, auto_r};
            `SSHCU_ADR_IRQS: wb_dat_o <= {29'h00000000, irq_stat_r};
            `SSHCU_ADR_IRQM: wb_dat_o <= {29'h00000000, irq_mask_r};
            default: wb_dat_o <= 32'h00000000;
         endcase
         if (wb_wr && wb_adr_i == `SSHCU_ADR_CTRL && wb_sel_i[0]) begin
            baud_sel_r <= wb_dat_i[2:0];
            stop2_r <= wb_dat_i[3];
            par_r <= wb_dat_i[5:4];
         end
         if (wb_wr && wb_adr_i == `SSHCU_ADR_CTRL && wb_sel_i[1])
            auto_ch_r <= wb_dat_i[10:8];
         if (wb_wr && wb_adr_i == `SSHCU_ADR_IRQM && wb_sel_i[0])
            irq_mask_r <= wb_dat_i[2:0];
         // set wins over write-one clear
         irq_stat_r <= (irq_stat_r
            & ~((wb_wr && wb_adr_i == `SSHCU_ADR_IRQS && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0))
            | {rx_done & rx_err, ev_nak, ev_cmd};
      end
   end

   assign irq_o = |(irq_stat_r & irq_mask_r);
endmodule
`default_nettype wire

// ===== sshcu_top_asserts.sv
// port assertions of the serial command unit
`default_nettype none
module sshcu_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic txd_o,
   input wire logic head_in_zone_i,
   input wire logic rts_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_mask_off;
      wb_ack_o && wb_we_i && wb_adr_i == 4'hC && wb_sel_i[0] && wb_dat_i[2:0] == 3'h0;
   endsequence
   a_ack_next: assert property (s_req |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   a_rts_present: assert property (head_in_zone_i [*8] |-> rts_o)
      else $error("rts low with head present");
   a_rts_absent: assert property (!head_in_zone_i [*8] |-> !rts_o)
      else $error("rts high without head");
   a_reset_idle: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i |=> txd_o && !rts_o && !irq_o && !wb_ack_o) else $error("outputs not idle");
   a_irq_masked: assert property (s_mask_off |=> !irq_o)
      else $error("irq high with mask cleared");
   a_start_len: assert property ($fell(txd_o) |-> !txd_o [*8])
      else $error("start bit too short");
endmodule
bind sshcu_top sshcu_chk i_sshcu_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .txd_o(txd_o),
   .head_in_zone_i(head_in_zone_i), .rts_o(rts_o), .irq_o(irq_o));
`default_nettype wire

// ===== sshcu_host.sv
// host side serial link model
`default_nettype none
module sshcu_host (
   input wire logic clk_i,
   input wire logic rx_i,
   output logic tx_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int bc = 10;
   logic [1:0] par = 2'h0;
   logic st2 = 1'b0;
   logic bad = 1'b0;
   logic [7:0] rb;
   logic [7:0] q[$];
   initial tx_o = 1'b1;
   task automatic bit_out(input logic b);
      tx_o <= b;
      repeat (bc) @(posedge clk_i);
   endtask
   task automatic send(input logic [7:0] b);
      @(posedge clk_i);
      bit_out(1'b0);
      for (int i = 0; i < 8; i++) bit_out(b[i]);
      if (par != 2'h0) bit_out(^b ^ par[1] ^ bad);
      repeat (st2 ? 2 : 1) bit_out(1'b1);
   endtask
   initial forever begin
      @(negedge rx_i);
      repeat (bc / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (bc) @(posedge clk_i);
         rb[i] = rx_i;
      end
      repeat (par != 2'h0 ? 2 * bc : bc) @(posedge clk_i);
      q.push_back(rb);
   end
endmodule
`default_nettype wire

// ===== tb_sshcu_top.sv
// testbench of the serial command unit
`default_nettype none
module tb_sshcu_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HZ = 1152000;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic we = 1'b0, cyc = 1'b0, stb = 1'b0, head = 1'b1;
   logic [3:0] sel = 4'h0, lane = 4'hF;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] dat_o;
   logic [127:0] temp = 128'h1A2F;
   logic [7:0] conn = 8'hFF;
   logic ack, txd, rxd, rts, irq;
   int error_cnt = 0;
   int compares = 0;
   int rate[6] = '{57600, 38400, 19200, 9600, 4800, 115200};
   always #20 clk_i = ~clk_i;
   sshcu_top #(.CLK_HZ(HZ)) i_sshcu_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_ack_o(ack), .rxd_i(rxd), .txd_o(txd), .head_in_zone_i(head),
      .rts_o(rts), .temp_i(temp), .sensor_conn_i(conn), .irq_o(irq));
   sshcu_host i_sshcu_host (.clk_i(clk_i), .rx_i(txd), .tx_o(rxd));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      adr <= a;
      we <= w;
      wdat <= d;
      sel <= lane;
      do @(posedge clk_i); while (ack !== 1'b1);
      r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(a, 1'b1, d, r);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(a, 1'b0, 32'h0, r);
      chk(r, e);
   endtask
   task automatic cmd(input string s, input string e);
      int n;
      for (int i = 0; i < s.len(); i++) i_sshcu_host.send(s[i]);
      for (int i = 0; i < e.len(); i++) begin
         n = 0;
         while (i_sshcu_host.q.size() == 0 && n < 40000) begin
            @(posedge clk_i);
            n++;
         end
         if (n < 40000) chk({24'h0, i_sshcu_host.q.pop_front()}, {24'h0, e[i]});
         else chk(32'hFFFFFFFF, {24'h0, e[i]});
      end
      repeat (2 * i_sshcu_host.bc) @(posedge clk_i);
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk_i);
      error_cnt++;
      close_out();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk({29'h0, rts, txd, irq}, 32'h6);
      rd(4'h0, 32'h0);
      cmd("D1", "11A2F\015");
      cmd("D9", "\0258");
      cmd("Q", "\0257");
      conn <= 8'hFD;
      cmd("D2", "\0252");
      head <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk({31'h0, rts}, 32'h0);
      cmd("D1", "\0251");
      head <= 1'b1;
      $display("command tests done");
      lane = 4'h2;
      wr(4'h0, 32'h118);
      lane = 4'hF;
      rd(4'h0, 32'h100);
      cmd("AS", "\006");
      rd(4'h4, 32'h3);
      temp <= 128'hB7_0000;
      cmd("", "200B7\015");
      head <= 1'b0;
      repeat (8) @(posedge clk_i);
      temp <= 128'hC4_0000;
      repeat (400) @(posedge clk_i);
      chk(i_sshcu_host.q.size(), 32'h0);
      head <= 1'b1;
      cmd("", "200C4\015");
      cmd("AE", "\006");
      rd(4'h4, 32'h2);
      temp <= 128'hC00;
      repeat (400) @(posedge clk_i);
      chk(i_sshcu_host.q.size(), 32'h0);
      $display("mode tests done");
      rd(4'h8, 32'h3);
      chk({31'h0, irq}, 32'h0);
      wr(4'hC, 32'h2);
      chk({31'h0, irq}, 32'h1);
      wr(4'h8, 32'h3);
      chk({31'h0, irq}, 32'h0);
      rd(4'h8, 32'h0);
      rd(4'h2, 32'h0);
      $display("register tests done");
      wr(4'h0, 32'h18);
      i_sshcu_host.par = 2'h1;
      i_sshcu_host.st2 = 1'b1;
      cmd("D1", "10C00\015");
      i_sshcu_host.bad = 1'b1;
      cmd("D", "\0256");
      i_sshcu_host.bad = 1'b0;
      rd(4'h8, 32'h7);
      chk({31'h0, irq}, 32'h1);
      wr(4'hC, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(4'h0, 32'h20);
      i_sshcu_host.par = 2'h2;
      i_sshcu_host.st2 = 1'b0;
      cmd("AE", "\006");
      i_sshcu_host.par = 2'h0;
      for (int k = 0; k < 6; k++) begin
         wr(4'h0, (k + 1) % 6);
         i_sshcu_host.bc = HZ / rate[k];
         cmd("AE", "\006");
      end
      $display("frame tests done");
      close_out();
   end
endmodule
`default_nettype wire
